// >>> fieldbus_master_model.sv
// Behavioural fieldbus master that writes cyclic command data
`timescale 1ns/1ns

module fieldbus_master_model (
    input  wire logic        i_core_clk,
    output logic             o_cmd_update,
    output logic [15:0]      o_command_word_low,
    output logic [15:0]      o_command_word_high,
    output logic [31:0]      o_position,
    output logic [15:0]      o_motor_current,
    output logic [15:0]      o_jerk
);
    initial begin
        o_cmd_update = 1'b0;
        {o_command_word_low, o_command_word_high} = 32'h0000_0000;
        {o_position, o_motor_current, o_jerk} = 64'h0;
    end

    // Callers may raise more than one low-word bit per update
    // and may repeat the low word without zeroing it between commands
    task automatic put(input logic [15:0] lo, input logic [15:0] hi,
                       input logic [31:0] pos, input logic [15:0] cur,
                       input logic [15:0] jrk);
        @(negedge i_core_clk);
        o_command_word_low  = lo;
        o_command_word_high = hi;
        o_position          = pos;
        o_motor_current     = cur;
        o_jerk              = jrk;
        // Strobe spans one rising edge; data then stays as a level
        o_cmd_update        = 1'b1;
        @(negedge i_core_clk);
        o_cmd_update        = 1'b0;
    endtask
endmodule // fieldbus_master_model

// >>> stepper_cfg_check.sv
// Configuration validity checker of the command decoder
`timescale 1ns/1ns
`include "stepper_cmd_params.svh"

module stepper_cfg_check
    import stepper_cmd_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_cfg_reserved,
    input  wire logic [5:0]  i_cfg_gain,
    input  wire logic [7:0]  i_cfg_current,
    input  wire logic [7:0]  i_cfg_idle,
    input  wire logic [2:0]  i_in1_func,
    input  wire logic [2:0]  i_in2_func,
    input  wire logic [2:0]  i_in3_func,
    input  wire logic        i_enc_en,
    input  wire logic [15:0] i_enc_res,
    input  wire logic        i_stall_en,
    output logic             o_invalid
);
    chk_state_t s;
    chk_state_t next_s;
    logic [7:0] cur_max;
    logic       dup;

    assign cur_max = SMALL_VARIANT ? `CUR_MAX_SMALL : `CUR_MAX_LARGE;

    // Duplicate function, general purpose excepted; A and B share a code
    always_comb begin
        dup = 1'b0;
        if (i_in1_func == i_in2_func && i_in1_func != `IN_FN_GP
            && i_in1_func != `IN_FN_QUAD)
            dup = 1'b1;
        if (i_in1_func == i_in3_func && i_in1_func != `IN_FN_GP)
            dup = 1'b1;
        if (i_in2_func == i_in3_func && i_in2_func != `IN_FN_GP)
            dup = 1'b1;
    end

    always_comb begin
        next_s = s;
        next_s.invalid =
            (|i_cfg_reserved)
            || !in_range8({2'b00, i_cfg_gain}, {2'b00, `GAIN_MIN},
                          {2'b00, `GAIN_MAX})
            || !in_range8(i_cfg_current, `CUR_MIN, cur_max)
            || (i_cfg_idle > i_cfg_current)
            || dup
            || (i_in3_func == `IN_FN_BAD)
            || (i_enc_en && (i_in1_func != `IN_FN_QUAD
                             || i_in2_func != `IN_FN_QUAD))
            || (i_enc_en && i_enc_res == 16'h0000)
            || (i_stall_en && !i_enc_en);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s <= '{invalid: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign o_invalid = s.invalid;

    in3_pattern_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_in3_func == `IN_FN_BAD |=> o_invalid)
        else $error("input 3 pattern 111 not flagged");

    stall_no_enc_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_stall_en && !i_enc_en) |=> o_invalid)
        else $error("stall watch without encoder not flagged");

endmodule // stepper_cfg_check

// >>> stepper_cmd_params.svh
// Bit positions, limits and reset values of the command decoder
`ifndef STEPPER_CMD_PARAMS_SVH
`define STEPPER_CMD_PARAMS_SVH

// First command word
`define LOW_MODE_SEL        15
`define LOW_PRESET_ENC      14
`define LOW_RUN_PROFILE     13
`define LOW_READ_PROFILE    12
`define LOW_PROG_PROFILE    11
`define LOW_RESET_ERR       10
`define LOW_PRESET_POS      9
`define LOW_JOG_COUNTERCLOCKWISE_CMD         8
`define LOW_JOG_CW          7
`define LOW_HOME_CCW        6
`define LOW_HOME_CW         5
`define LOW_STOP            4
`define LOW_RESUME          3
`define LOW_HOLD            2
`define LOW_REL_MOVE        1
`define LOW_ABS_MOVE        0
// Commands that start motion and may wait for the sync event
`define MOVE_MASK           16'h21E3

// Second command word
`define HIGH_EN_DRIVER      15
`define HIGH_CLR_FAULT      10
`define HIGH_DWELL_TYPE     9
`define HIGH_REG_MOVE       7
`define HIGH_GEARING        6
`define HIGH_KEY2           5
`define HIGH_REV_BLEND      4
`define HIGH_KEY1           1
`define HIGH_KEY0           0

// Loop gain
`define GAIN_MIN            6'h01
`define GAIN_MAX            6'h28
`define GAIN_DEF            6'h05

// Motor current in tenths of an amp
`define CUR_MIN             8'h0A
`define CUR_MAX_LARGE       8'h3C
`define CUR_MAX_SMALL       8'h2D
`define CUR_RESET           8'h0A

// Input function codes
`define IN_FN_GP            3'h0
`define IN_FN_QUAD          3'h1
`define IN_FN_BAD           3'h7

`endif

// >>> stepper_cmd_pkg.sv
// Types and shared helpers of the command decoder
package stepper_cmd_pkg;

    typedef struct packed {
        logic        invalid;
    } chk_state_t;

    typedef struct packed {
        logic [15:0] prev_low;
        logic [15:0] pending;
        logic        sync_ff1;
        logic        sync_ff2;
        logic        sync_prev;
        logic [14:0] pulse;
        logic        dwell;
        logic        ccw;
        logic        reg_move;
        logic        clr_fault;
        logic [15:0] dwell_ms;
        logic [31:0] preset_val;
        logic        done_flag;
        logic [5:0]  gain;
        logic [7:0]  motor_current;
        logic        cur_reject;
        logic [7:0]  idle_pend;
        logic        idle_pend_v;
        logic [7:0]  idle_cur;
        logic        cfg_ok;
        logic        enable;
        logic        gear;
        logic        cfg_err;
    } dec_state_t;

    function automatic logic in_range8(input logic [7:0] v,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

endpackage

// >>> stepper_command_word_decoder.sv
// Cyclic command word decoder of the networked stepper indexer
//
// Overview of operation
// - Loop gain 1 to 40, default 5.
// - New idle current applies after next move.
// - Current limited per variant; command value even.
// - Nonzero reserved configuration bit is invalid.
// - Out of range parameter is invalid.
// - Duplicate input function invalid, except general purpose or quadrature on inputs one, two.
// - Third input pattern 111 is invalid.
// - Encoder needs inputs one, two as quadrature.
// - Encoder needs nonzero counts per turn.
// - Stall watching needs encoder use.
// - Low-word commands act only on rising bit edges.
// - Two command words, then parameter words.
// - Mode select bit must be zero.
// - Bit 14 edge presets encoder position.
// - Bit 13 runs profile; type, direction qualifiers.
// - Dwell time taken from jerk word, milliseconds.
// - Bits 11, 12 program and read profile.
// - Bit 10 clears errors, done, optionally fault.
// - Bit 9 presets motor position, clears done.
// - Bit 8 jogs counter-clockwise, or registration.
// - Gearing follows only while a jog bit set.
// - Aligned mode holds move start for sync.
`timescale 1ns/1ns
`include "stepper_cmd_params.svh"

module stepper_command_word_decoder
    import stepper_cmd_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0,
    parameter int CUR_W         = 8
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_cmd_update,
    input  wire logic [15:0] i_command_word_low,
    input  wire logic [15:0] i_command_word_high,
    input  wire logic [31:0] i_position,
    input  wire logic [31:0] i_velocity,
    input  wire logic [15:0] i_accel,
    input  wire logic [15:0] i_decel,
    input  wire logic [15:0] i_motor_current,
    input  wire logic [15:0] i_jerk,
    input  wire logic        i_dist_clock_align,
    input  wire logic        i_sync0,
    input  wire logic        i_move_done,
    input  wire logic        i_cfg_load,
    input  wire logic [15:0] i_cfg_reserved,
    input  wire logic [5:0]  i_cfg_gain,
    input  wire logic [7:0]  i_cfg_current,
    input  wire logic [7:0]  i_cfg_idle,
    input  wire logic [2:0]  i_in1_func,
    input  wire logic [2:0]  i_in2_func,
    input  wire logic [2:0]  i_in3_func,
    input  wire logic        i_enc_en,
    input  wire logic [15:0] i_enc_res,
    input  wire logic        i_stall_en,
    output logic [14:0]      o_cmd_pulse,
    output logic             o_profile_dwell,
    output logic             o_profile_ccw,
    output logic             o_registration,
    output logic             o_clear_amp_fault,
    output logic [15:0]      o_dwell_ms,
    output logic [31:0]      o_preset_value,
    output logic             o_move_done,
    output logic [5:0]       o_gain,
    output logic [7:0]       o_motor_current,
    output logic             o_current_rejected,
    output logic [7:0]       o_idle_current,
    output logic             o_motor_enable,
    output logic             o_gear_follow,
    output logic             o_cfg_error
);
    if (CUR_W != 8) begin : g_bad_width
        $error("CUR_W must be 8");
    end

    dec_state_t s;
    dec_state_t next_s;
    logic        chk_invalid;
    logic [15:0] rise;
    logic [15:0] fire;
    logic [15:0] release_mv;
    logic        sync_rise;
    logic        key_set;
    logic        cur_ok;
    logic [7:0]  cur_max;

    stepper_cfg_check #(
        .SMALL_VARIANT (SMALL_VARIANT)
    ) u_cfg_check (
        .i_core_clk     (i_core_clk),
        .i_sys_rst      (i_sys_rst),
        .i_cfg_reserved (i_cfg_reserved),
        .i_cfg_gain     (i_cfg_gain),
        .i_cfg_current  (i_cfg_current),
        .i_cfg_idle     (i_cfg_idle),
        .i_in1_func     (i_in1_func),
        .i_in2_func     (i_in2_func),
        .i_in3_func     (i_in3_func),
        .i_enc_en       (i_enc_en),
        .i_enc_res      (i_enc_res),
        .i_stall_en     (i_stall_en),
        .o_invalid      (chk_invalid)
    );

    assign cur_max = SMALL_VARIANT ? `CUR_MAX_SMALL : `CUR_MAX_LARGE;

    always_comb begin
        next_s = s;
        next_s.pulse = '0;
        next_s.sync_ff1 = i_sync0;
        next_s.sync_ff2 = s.sync_ff1;
        next_s.sync_prev = s.sync_ff2;
        sync_rise = s.sync_ff2 & ~s.sync_prev;

        rise = i_command_word_low & ~s.prev_low;
        rise[`LOW_MODE_SEL] = 1'b0;
        fire = '0;
        if (i_cmd_update) begin
            next_s.prev_low = i_command_word_low;
            if (!i_command_word_low[`LOW_MODE_SEL])
                fire = rise;
        end

        // Qualifiers are caught with the edge that uses them
        if (|fire) begin
            next_s.dwell = i_command_word_high[`HIGH_DWELL_TYPE];
            next_s.ccw = i_command_word_high[`HIGH_REV_BLEND];
            next_s.dwell_ms = i_jerk;
            next_s.reg_move = i_command_word_high[`HIGH_REG_MOVE];
            next_s.preset_val = i_position;
            next_s.clr_fault = fire[`LOW_RESET_ERR]
                & i_command_word_high[`HIGH_CLR_FAULT];
        end

        // Motion starts wait for the sync edge when aligned
        release_mv = '0;
        if (i_dist_clock_align) begin
            if (sync_rise) begin
                release_mv = s.pending;
                next_s.pending = fire & `MOVE_MASK;
            end else begin
                next_s.pending = s.pending | (fire & `MOVE_MASK);
            end
        end else begin
            release_mv = s.pending | (fire & `MOVE_MASK);
            next_s.pending = '0;
        end
        // Profile program/read bits 11 and 12 pass straight through
        next_s.pulse = release_mv[14:0]
            | (fire[14:0] & ~(15'(`MOVE_MASK)));

        // Done flag: a completing move wins over a clear
        next_s.done_flag = (s.done_flag & ~fire[`LOW_RESET_ERR]
            & ~fire[`LOW_PRESET_POS]) | i_move_done;

        // On the fly current change through the key pattern
        key_set = i_cmd_update && !i_command_word_low[`LOW_MODE_SEL]
            && i_command_word_high[`HIGH_KEY2]
            && !i_command_word_high[`HIGH_KEY1]
            && i_command_word_high[`HIGH_KEY0];
        cur_ok = (i_motor_current[15:8] == 8'h00)
            && !i_motor_current[0]
            && in_range8(i_motor_current[7:0], `CUR_MIN, cur_max);
        if (fire[`LOW_RESET_ERR])
            next_s.cur_reject = 1'b0;
        if (key_set) begin
            if (cur_ok)
                next_s.motor_current = i_motor_current[7:0];
            else
                next_s.cur_reject = 1'b1;
        end

        // Idle current waits for the first completed move
        if (i_move_done && s.idle_pend_v) begin
            next_s.idle_cur = s.idle_pend;
            next_s.idle_pend_v = 1'b0;
        end
        if (i_cfg_load && !chk_invalid) begin
            next_s.gain = i_cfg_gain;
            next_s.motor_current = i_cfg_current;
            next_s.idle_pend = i_cfg_idle;
            next_s.idle_pend_v = 1'b1;
            next_s.cfg_ok = 1'b1;
        end else if (i_cfg_load) begin
            next_s.cfg_ok = 1'b0;
        end

        next_s.cfg_err = chk_invalid;
        next_s.enable = i_command_word_high[`HIGH_EN_DRIVER]
            && next_s.cfg_ok && !chk_invalid;
        next_s.gear = i_command_word_high[`HIGH_GEARING]
            && (i_command_word_low[`LOW_JOG_CW]
                || i_command_word_low[`LOW_JOG_COUNTERCLOCKWISE_CMD]);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            s <= '0;
            s.gain <= `GAIN_DEF;
            s.motor_current <= `CUR_RESET;
            s.idle_cur <= `CUR_RESET;
            s.idle_pend <= `CUR_RESET;
            s.cfg_err <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign o_cmd_pulse        = s.pulse;
    assign o_profile_dwell    = s.dwell;
    assign o_profile_ccw      = s.ccw;
    assign o_registration     = s.reg_move;
    assign o_clear_amp_fault  = s.clr_fault;
    assign o_dwell_ms         = s.dwell_ms;
    assign o_preset_value     = s.preset_val;
    assign o_move_done        = s.done_flag;
    assign o_gain             = s.gain;
    assign o_motor_current    = s.motor_current;
    assign o_current_rejected = s.cur_reject;
    assign o_idle_current     = s.idle_cur;
    assign o_motor_enable     = s.enable;
    assign o_gear_follow      = s.gear;
    assign o_cfg_error        = s.cfg_err;

    gain_default_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        $past(i_sys_rst) |-> o_gain == `GAIN_DEF)
        else $error("gain not at default after reset");

    idle_apply_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_move_done && s.idle_pend_v && !i_cfg_load)
        |=> o_idle_current == $past(s.idle_pend))
        else $error("idle current not applied at move end");

    odd_current_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (key_set && i_motor_current[0] && !i_cfg_load)
        |=> $stable(o_motor_current) && o_current_rejected)
        else $error("odd motor current accepted");

    edge_only_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_cmd_update && s.prev_low[`LOW_RESET_ERR]
         && i_command_word_low[`LOW_RESET_ERR])
        |=> !o_cmd_pulse[`LOW_RESET_ERR])
        else $error("command acted on a held level");

    mode_block_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_cmd_update && i_command_word_low[`LOW_MODE_SEL])
        |=> (o_cmd_pulse & ~(15'(`MOVE_MASK))) == 15'h0000)
        else $error("command acted on outside command mode");

    enc_preset_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        fire[`LOW_PRESET_ENC] |=> o_cmd_pulse[`LOW_PRESET_ENC]
            && o_preset_value == $past(i_position))
        else $error("encoder preset missing or wrong value");

    done_clear_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (fire[`LOW_PRESET_POS] && !i_move_done) |=> !o_move_done)
        else $error("position preset did not clear done");

    sync_hold_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dist_clock_align && !sync_rise)
        |=> (o_cmd_pulse & 15'(`MOVE_MASK)) == 15'h0000)
        else $error("aligned move started without sync edge");

    enable_block_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_cfg_error |-> !o_motor_enable)
        else $error("motor enabled with invalid configuration");

    gear_gate_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_gear_follow |-> $past(i_command_word_low[`LOW_JOG_CW]
            || i_command_word_low[`LOW_JOG_COUNTERCLOCKWISE_CMD]))
        else $error("gearing follows without a jog bit");

    reset_err_clr_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (fire[`LOW_RESET_ERR] && !i_move_done)
        |=> !o_move_done && o_clear_amp_fault
            == $past(i_command_word_high[`HIGH_CLR_FAULT]))
        else $error("reset errors did not clear done or fault");

    jog_reg_a: assert property (
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (fire[`LOW_JOG_COUNTERCLOCKWISE_CMD] && !i_dist_clock_align)
        |=> o_cmd_pulse[`LOW_JOG_COUNTERCLOCKWISE_CMD]
            && o_registration == $past(i_command_word_high[`HIGH_REG_MOVE]))
        else $error("counter-clockwise jog missing or wrong type");

endmodule // stepper_command_word_decoder

// >>> tb_top.sv
// Self-checking bench of the stepper command word decoder
`timescale 1ns/1ns

module tb_top;
    logic        i_core_clk = 1'b0, i_sys_rst = 1'b1, i_cmd_update;
    logic        i_dist_clock_align = 1'b0, i_sync0 = 1'b0;
    logic        i_move_done = 1'b0, i_cfg_load = 1'b0;
    logic        i_enc_en, i_stall_en, ok, seen;
    logic        o_profile_dwell, o_profile_ccw, o_registration;
    logic        o_clear_amp_fault, o_move_done, o_current_rejected;
    logic        o_motor_enable, o_gear_follow, o_cfg_error;
    logic [2:0]  i_in1_func, i_in2_func, i_in3_func;
    logic [5:0]  i_cfg_gain, o_gain;
    logic [7:0]  i_cfg_current, i_cfg_idle, o_motor_current;
    logic [7:0]  o_idle_current, last_cur;
    logic [14:0] o_cmd_pulse;
    logic [15:0] i_command_word_low, i_command_word_high, i_motor_current;
    logic [15:0] i_jerk, i_cfg_reserved, i_enc_res, o_dwell_ms, w;
    logic [15:0] i_accel = 16'h0000, i_decel = 16'h0000;
    logic [15:0] c_v = 16'h0000, j_v = 16'h0000, h_v = 16'h0000;
    logic [31:0] i_position, o_preset_value, p_v = 32'h0000_0000;
    logic [31:0] i_velocity = 32'h0000_0000;
    logic [15:0] cur_tab [5] = '{16'h000A, 16'h0032, 16'h0033, 16'h003E,
                                 16'h0008};
    int          bad_count = 0, compares = 0;

    stepper_command_word_decoder #(
        .SMALL_VARIANT (1'b0),
        .CUR_W         (8)
    ) i_stepper_command_word_decoder (.*);

    fieldbus_master_model i_fieldbus_master_model (
        .i_core_clk          (i_core_clk),
        .o_cmd_update        (i_cmd_update),
        .o_command_word_low  (i_command_word_low),
        .o_command_word_high (i_command_word_high),
        .o_position          (i_position),
        .o_motor_current     (i_motor_current),
        .o_jerk              (i_jerk)
    );

    always #5 i_core_clk = ~i_core_clk;

    task automatic tk(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    task automatic send(input logic [15:0] lo, input logic [15:0] hi);
        i_fieldbus_master_model.put(lo, hi, p_v, c_v, j_v);
    endtask

    task automatic done_pulse();
        i_move_done = 1'b1;
        tk(1);
        i_move_done = 1'b0;
    endtask

    task automatic chk(input string what, input logic [63:0] seen_v,
                       input logic [63:0] exp_v);
        compares++;
        if (seen_v !== exp_v) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp_v, seen_v);
        end
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Valid base set, then one change per case number; cases 10 and 11 stay valid
    task automatic cfg_case(input int k);
        {i_cfg_reserved, i_cfg_gain, i_cfg_current, i_cfg_idle} =
            {16'h0000, 6'h28, 8'h3C, 8'h14};
        {i_in1_func, i_in2_func, i_in3_func, i_enc_en, i_enc_res, i_stall_en} =
            {3'h0, 3'h0, 3'h0, 1'b0, 16'h0400, 1'b0};
        case (k)
            1: i_cfg_reserved = 16'h8000;
            2: i_cfg_gain = 6'h00;
            3: i_cfg_gain = 6'h29;
            4: i_cfg_current = 8'h09;
            5: {i_in1_func, i_in2_func} = {3'h2, 3'h2};
            6: i_in3_func = 3'h7;
            7: i_enc_en = 1'b1;
            8: {i_enc_en, i_in1_func, i_in2_func, i_enc_res} =
                   {1'b1, 3'h1, 3'h1, 16'h0000};
            9: i_stall_en = 1'b1;
            10: {i_enc_en, i_in1_func, i_in2_func, i_stall_en} =
                    {1'b1, 3'h1, 3'h1, 1'b1};
            11: i_cfg_gain = 6'h01;
            12: i_cfg_current = 8'h3D;
            default: ;
        endcase
    endtask

    initial begin
        cfg_case(0);
        tk(10);
        chk("pulse", o_cmd_pulse, 15'h0000);
        chk("gain", o_gain, 6'h05);
        chk("current", o_motor_current, 8'h0A);
        chk("idle", o_idle_current, 8'h0A);
        chk("cfg_error", o_cfg_error, 1'b1);
        chk("enable", o_motor_enable, 1'b0);
        i_sys_rst = 1'b0;
        tk(2);
        i_cfg_load = 1'b1;
        tk(1);
        i_cfg_load = 1'b0;
        tk(2);
        chk("gain", o_gain, 6'h28);
        chk("current", o_motor_current, 8'h3C);
        chk("idle", o_idle_current, 8'h0A);
        done_pulse();
        tk(1);
        chk("idle", o_idle_current, 8'h14);
        for (int k = 0; k < 13; k++) begin
            cfg_case(k);
            tk(3);
            ok = (k == 0 || k == 10 || k == 11);
            chk("cfg_error", o_cfg_error, !ok);
        end
        cfg_case(0);
        tk(3);
        // Every command bit, qualifiers on alternate pairs, held, cleared
        for (int n = 0; n < 15; n++) begin
            done_pulse();
            w = 16'h0000;
            w[n] = 1'b1;
            p_v = {28'h8000000, 4'(n)};
            j_v = {12'hFFF, 4'(n)};
            h_v = n[1] ? 16'h0690 : 16'h0000;
            send(w, h_v);
            chk("pulse", o_cmd_pulse, w[14:0]);
            chk("dwell", o_profile_dwell, n[1]);
            chk("ccw", o_profile_ccw, n[1]);
            chk("registration", o_registration, n[1]);
            chk("amp_fault", o_clear_amp_fault, n == 10);
            chk("dwell_ms", o_dwell_ms, j_v);
            chk("preset", o_preset_value, p_v);
            chk("done", o_move_done, !(n == 9 || n == 10));
            tk(1);
            chk("pulse", o_cmd_pulse, 15'h0000);
            send(w, h_v);
            chk("pulse", o_cmd_pulse, 15'h0000);
            send(16'h0000, h_v);
        end
        send(16'h8001, 16'h0000);
        chk("pulse", o_cmd_pulse, 15'h0000);
        send(16'h0001, 16'h0000);
        chk("pulse", o_cmd_pulse, 15'h0000);
        send(16'h0000, 16'h0000);
        i_dist_clock_align = 1'b1;
        send(16'h0001, 16'h0000);
        tk(2);
        chk("pulse", o_cmd_pulse, 15'h0000);
        i_sync0 = 1'b1;
        tk(1);
        chk("pulse", o_cmd_pulse, 15'h0000);
        seen = 1'b0;
        for (int t = 0; t < 5; t++) begin
            tk(1);
            seen = seen | (o_cmd_pulse[0] === 1'b1);
        end
        chk("aligned", seen, 1'b1);
        send(16'h0000, 16'h0000);
        send(16'h0010, 16'h0000);
        chk("pulse", o_cmd_pulse, 15'h0010);
        send(16'h0000, 16'h0000);
        i_sync0 = 1'b0;
        i_dist_clock_align = 1'b0;
        // Current key: accepted only if even and inside the run range
        last_cur = 8'h3C;
        for (int i = 0; i < 5; i++) begin
            c_v = cur_tab[i];
            ok = !c_v[0] && c_v >= 16'h000A && c_v <= 16'h003C;
            if (ok) last_cur = c_v[7:0];
            send(16'h0000, 16'h0021);
            chk("rejected", o_current_rejected, !ok);
            chk("current", o_motor_current, last_cur);
            send(16'h0400, 16'h0000);
            chk("rejected", o_current_rejected, 1'b0);
            send(16'h0000, 16'h0000);
        end
        send(16'h0080, 16'h0040);
        chk("gear", o_gear_follow, 1'b1);
        send(16'h0000, 16'h0040);
        chk("gear", o_gear_follow, 1'b0);
        send(16'h0100, 16'h0040);
        chk("gear", o_gear_follow, 1'b1);
        send(16'h0100, 16'h0000);
        chk("gear", o_gear_follow, 1'b0);
        send(16'h0000, 16'h8000);
        tk(1);
        chk("enable", o_motor_enable, 1'b1);
        cfg_case(9);
        tk(3);
        chk("enable", o_motor_enable, 1'b0);
        end_of_test();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge i_core_clk);
        bad_count++;
        end_of_test();
    end
endmodule // tb_top
